// ==== buck_ctrl_cfg.svh ====
// timing and threshold constants for the buck switching control logic
`ifndef BUCK_CTRL_CFG_SVH
`define BUCK_CTRL_CFG_SVH

// core clock, kHz and ns
`define CLK_KHZ            200000
`define CLK_PERIOD_NS      5
// internal oscillator period in core cycles (200 MHz / 500 kHz default)
`define OSC_PERIOD_DEF     16'd400
// sync-clock loss timeout, us, and derived cycle count (rounded down)
`define SYNC_LOSS_US       10
`define SYNC_LOSS_CYC      ((`SYNC_LOSS_US * `CLK_KHZ) / 1000)
// least high-side off time, ns, rounded up to cycles
`define MIN_OFF_NS         200
`define MIN_OFF_CYC        ((`MIN_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// clamp persistence and hiccup wait, in switching cycles
`define CLAMP_LIMIT        512
`define HICCUP_CYCLES      16384
// counter widths
`define TMR_W              16
`define SW_CNT_W           15

`endif

// ==== buck_ctrl_chk.sv ====
// assertion checker for the buck switching control logic
`timescale 1ns/1ps
`default_nettype none
module buck_ctrl_chk (
    // watched ports
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic freq_set_sync_pin_i,
    input wire logic freq_set_sync_pin_oe_o,
    input wire logic supply_ok_i,
    input wire logic enable_ok_i,
    input wire logic boot_ok_i,
    input wire logic overvoltage_guard_i,
    input wire logic peak_limit_i,
    input wire logic ls_sink_limit_i,
    input wire logic high_side_on_o,
    input wire logic low_side_on_o,
    input wire logic mode_external_o,
    input wire logic shutdown_o,
    input wire logic hiccup_o
);
    logic [3:0]  peak_run;
    logic [3:0]  sink_run;
    logic [11:0] quiet;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // gate run lengths under a trip; saturate so they never wrap back to legal
    always_ff @(posedge clk_i) begin
        if (reset_i || !(high_side_on_o && peak_limit_i)) peak_run <= 4'h0;
        else if (peak_run != 4'hf) peak_run <= peak_run + 4'h1;
    end
    always_ff @(posedge clk_i) begin
        if (reset_i || !(low_side_on_o && ls_sink_limit_i)) sink_run <= 4'h0;
        else if (sink_run != 4'hf) sink_run <= sink_run + 4'h1;
    end
    // cycles since the sync pin last moved
    always_ff @(posedge clk_i) begin
        if (reset_i || $changed(freq_set_sync_pin_i)) quiet <= 12'h000;
        else if (quiet != 12'hfff) quiet <= quiet + 12'h001;
    end

    property p_no_overlap; !(high_side_on_o && low_side_on_o); endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
    property p_pin_free; mode_external_o |-> !freq_set_sync_pin_oe_o; endproperty
    a_pin_free: assert property (p_pin_free) else $error("sync pin driven");
    property p_to_ext; $rose(freq_set_sync_pin_i) && !mode_external_o |-> ##[2:8] mode_external_o;
    endproperty
    a_to_ext: assert property (p_to_ext) else $error("sync rise not taken");
    property p_loss; $fell(mode_external_o) |-> quiet >= 12'd1995; endproperty
    a_loss: assert property (p_loss) else $error("early fall back");
    property p_loss_late; quiet == 12'd2030 |-> !mode_external_o; endproperty
    a_loss_late: assert property (p_loss_late) else $error("late fall back");
    property p_off; shutdown_o || hiccup_o |-> !high_side_on_o && !low_side_on_o; endproperty
    a_off: assert property (p_off) else $error("switching while off");
    property p_supply; (!supply_ok_i)[*8] |-> shutdown_o; endproperty
    a_supply: assert property (p_supply) else $error("active without supply");
    property p_enable; $fell(enable_ok_i) ##1 !enable_ok_i |-> ##[0:7] shutdown_o; endproperty
    a_enable: assert property (p_enable) else $error("enable low ignored");
    property p_ovp; overvoltage_guard_i[*8] |-> !high_side_on_o; endproperty
    a_ovp: assert property (p_ovp) else $error("high on in overvoltage");
    property p_boot; (!boot_ok_i)[*8] |-> !high_side_on_o; endproperty
    a_boot: assert property (p_boot) else $error("high on with low boot");
    property p_peak; peak_run <= 4'h7; endproperty
    a_peak: assert property (p_peak) else $error("peak trip ignored");
    property p_sink; sink_run <= 4'h7; endproperty
    a_sink: assert property (p_sink) else $error("sink trip ignored");

    c_high: cover property ($rose(high_side_on_o));
    c_ext: cover property ($rose(mode_external_o));
    c_hiccup: cover property ($rose(hiccup_o));
endmodule : buck_ctrl_chk

bind buck_switching_control_logic buck_ctrl_chk u_chk (.clk_i, .reset_i,
    .freq_set_sync_pin_i, .freq_set_sync_pin_oe_o, .supply_ok_i, .enable_ok_i, .boot_ok_i,
    .overvoltage_guard_i, .peak_limit_i, .ls_sink_limit_i, .high_side_on_o, .low_side_on_o,
    .mode_external_o, .shutdown_o, .hiccup_o);
`default_nettype wire

// ==== buck_ctrl_pkg.sv ====
// types for the buck switching control logic
`default_nettype none
package buck_ctrl_pkg;
    // frequency source
    typedef enum logic {
        resistor_set_mode,
        external_clock_mode
    } freq_mode_t;

    // switch-state sequencer
    typedef enum logic [2:0] {
        st_off,
        st_high_on,
        st_low_on,
        st_both_off,
        st_hiccup
    } sw_state_t;
endpackage : buck_ctrl_pkg
`default_nettype wire

// ==== buck_stage_model.sv ====
// behavioural model of the power stage current sense and the sync source
`timescale 1ns/1ps
`default_nettype none
module buck_stage_model (
    // clock and bench controls
    input  wire logic       clk_i,
    input  wire logic       sync_run_i,
    input  wire logic [7:0] ramp_i,
    // switch command from the control logic
    input  wire logic       high_side_on_i,
    // sensed current trip and sync pin drive
    output logic            peak_limit_o,
    output logic            sync_pin_o
);
    logic [7:0] ramp_cnt;

    // current ramps while the high side conducts; a zero ramp never trips
    always_ff @(posedge clk_i) begin
        ramp_cnt     <= high_side_on_i ? ramp_cnt + 8'h01 : 8'h00;
        peak_limit_o <= high_side_on_i && ramp_i != 8'h00 && ramp_cnt >= ramp_i;
    end

    // sync buffer: toggles only while enabled, rests low between bursts
    initial begin
        sync_pin_o = 1'b0;
        forever begin
            #24;
            // square wave; period kept short for run length, logic only needs edges
            sync_pin_o = sync_run_i ? ~sync_pin_o : 1'b0;
        end
    end
endmodule : buck_stage_model
`default_nettype wire

// ==== buck_switching_control_logic.sv ====
// switching-control sequencer of a synchronous buck converter
`timescale 1ns/1ps
`default_nettype none
`include "buck_ctrl_cfg.svh"

// Summary of operation
// [R1] run from internal oscillator until an external clock appears
// [R2] first rise on freq_set_sync_pin selects external mode and releases the pin
// [R3] after 10 us with no external edge, fall back to resistor_set_mode
// [R4] low-side on interval recharges the gate-drive capacitor
// [R5] high side may stay on continuously while gate-drive voltage is good
// [R6] off time below 200 ns stretches the cycle toward full duty
// [R7] gate-drive undervoltage turns high side off and low side on
// [R8] overvoltage holds high side off and low side on
// [R9] after overvoltage, high side resumes only at next cycle start
// [R10] peak-current trip ends the high pulse and turns low side on
// [R11] clamp over 512 cycles shuts down; restart after 16384 cycles
// [R12] low-side sourcing over limit at cycle end skips next high pulse
// [R13] high switching resumes at a cycle start with sourcing below limit
// [R14] sinking-limit trip turns low side off until next cycle
// [R15] low side re-enabled only after high on-off pulse or gate undervoltage
// [R16] active only when input supply and enable are both good
// [R17] enable low stops switching and enters shutdown
// [R18] external mode starts each cycle on the falling sync edge
// [R19] external source runs between 200 kHz and 1600 kHz
// [R20] every comparator input is synchronised before use
// [R21] high and low switches never conduct together
module buck_switching_control_logic
    import buck_ctrl_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    // oscillator setting from the timing resistor
    input  wire logic [15:0]       osc_period_i,
    // frequency-set / sync pin, three signals
    input  wire logic              freq_set_sync_pin_i,
    output logic                   freq_set_sync_pin_o,
    output logic                   freq_set_sync_pin_oe_o,
    // comparator results, asynchronous
    input  wire logic              supply_ok_i,
    input  wire logic              enable_ok_i,
    input  wire logic              boot_ok_i,
    input  wire logic              overvoltage_guard_i,
    input  wire logic              fb_below_106_i,
    input  wire logic              peak_limit_i,
    input  wire logic              comp_clamp_i,
    input  wire logic              ls_source_limit_i,
    input  wire logic              ls_sink_limit_i,
    // switch commands and status
    output logic                   high_side_on_o,
    output logic                   low_side_on_o,
    output logic                   mode_external_o,
    output logic                   shutdown_o,
    output logic                   hiccup_o
);
    import buck_ctrl_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] filt;

    assign raw_in = {freq_set_sync_pin_i, supply_ok_i, enable_ok_i, boot_ok_i,
                     overvoltage_guard_i, fb_below_106_i, peak_limit_i,
                     comp_clamp_i, ls_source_limit_i, ls_sink_limit_i};

    // three stages; a change is accepted once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            filt <= '0;
        end else if (ce_i) begin
            s1 <= raw_in;             // R20
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2[i] == s3[i]) begin
                    filt[i] <= s3[i];
                end
            end
        end
    end

    logic sync_pin;
    logic supply_ok;
    logic enable_ok;
    logic boot_ok;
    logic overvoltage_guard;
    logic fb_low;
    logic peak_trip;
    logic clamp;
    logic src_trip;
    logic sink_trip;
    assign {sync_pin, supply_ok, enable_ok, boot_ok, overvoltage_guard, fb_low, peak_trip,
            clamp, src_trip, sink_trip} = filt;

    // ------------------------------------------------------------
    // sync pin edges and frequency mode
    // ------------------------------------------------------------
    logic       sync_prev;
    logic       sync_rise;
    logic       sync_fall;
    freq_mode_t mode;
    logic [`TMR_W-1:0] loss_cnt;
    logic       active;

    assign sync_rise = sync_pin & ~sync_prev;
    assign sync_fall = ~sync_pin & sync_prev;
    assign active    = supply_ok & enable_ok;   // R16

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_prev <= 1'b0;
        end else if (ce_i) begin
            sync_prev <= sync_pin;
        end
    end

    // the pin reads the input threshold only; first rise switches source
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode     <= resistor_set_mode;   // R1
            loss_cnt <= '0;
        end else if (ce_i) begin
            unique case (mode)
                resistor_set_mode: begin
                    loss_cnt <= '0;
                    if (sync_rise) begin
                        mode <= external_clock_mode;   // R2
                    end
                end
                external_clock_mode: begin
                    if (sync_rise || sync_fall) begin
                        loss_cnt <= '0;
                    end else if (loss_cnt >= `TMR_W'(`SYNC_LOSS_CYC - 1)) begin
                        mode     <= resistor_set_mode;   // R3
                        loss_cnt <= '0;
                    end else begin
                        loss_cnt <= loss_cnt + `TMR_W'(1);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // cycle start generation
    // ------------------------------------------------------------
    logic [`TMR_W-1:0] osc_cnt;
    logic [`TMR_W-1:0] period;
    logic              osc_tick;
    logic              cycle_start;

    // a zero setting would stall the oscillator, so fall back to default
    assign period   = (osc_period_i == '0) ? `OSC_PERIOD_DEF : osc_period_i;
    assign osc_tick = (osc_cnt >= period - `TMR_W'(1));

    // oscillator free-runs in resistor mode; external mode uses falling edges
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            osc_cnt <= '0;
        end else if (ce_i) begin
            if (osc_tick || mode == external_clock_mode) begin
                osc_cnt <= '0;
            end else begin
                osc_cnt <= osc_cnt + `TMR_W'(1);
            end
        end
    end

    assign cycle_start = (mode == external_clock_mode) ? sync_fall : osc_tick;   // R18

    // ------------------------------------------------------------
    // hiccup timing, counted in switching cycles
    // ------------------------------------------------------------
    logic [`SW_CNT_W-1:0] clamp_cnt;
    logic [`SW_CNT_W-1:0] hic_cnt;
    logic                 hiccup;

    always_ff @(posedge clk_i) begin
        if (reset_i || (ce_i && !active)) begin
            clamp_cnt <= '0;
            hic_cnt   <= '0;
            hiccup    <= 1'b0;
        end else if (ce_i && cycle_start) begin
            if (hiccup) begin
                clamp_cnt <= '0;
                if (hic_cnt >= `SW_CNT_W'(`HICCUP_CYCLES - 1)) begin
                    hiccup  <= 1'b0;             // R11
                    hic_cnt <= '0;
                end else begin
                    hic_cnt <= hic_cnt + `SW_CNT_W'(1);
                end
            end else if (!clamp) begin
                clamp_cnt <= '0;
            end else if (clamp_cnt >= `SW_CNT_W'(`CLAMP_LIMIT)) begin
                hiccup    <= 1'b1;               // R11
                clamp_cnt <= '0;
            end else begin
                clamp_cnt <= clamp_cnt + `SW_CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // switch sequencer
    // ------------------------------------------------------------
    sw_state_t state;
    logic      skip_next;     // sourcing limit seen at cycle end
    logic      ovp_hold;      // overvoltage latched until fb falls
    logic      sink_block;    // low side barred after sinking trip
    logic [`TMR_W-1:0] off_cnt;
    logic      long_off;

    // low side re-armed by a full high pulse or by gate undervoltage
    always_ff @(posedge clk_i) begin
        if (reset_i || (ce_i && !active)) begin
            sink_block <= 1'b0;
        end else if (ce_i) begin
            if (state == st_low_on && sink_trip) begin
                sink_block <= 1'b1;              // R14
            end else if (!boot_ok || (state == st_high_on && (peak_trip || overvoltage_guard))) begin
                sink_block <= 1'b0;              // R15
            end
        end
    end

    // overvoltage release waits for fb below the lower threshold
    always_ff @(posedge clk_i) begin
        if (reset_i || (ce_i && !active)) begin
            ovp_hold <= 1'b0;
        end else if (ce_i) begin
            if (overvoltage_guard) begin
                ovp_hold <= 1'b1;                // R8
            end else if (fb_low && cycle_start) begin
                ovp_hold <= 1'b0;                // R9
            end
        end
    end

    // sourcing limit sampled at each cycle boundary
    always_ff @(posedge clk_i) begin
        if (reset_i || (ce_i && !active)) begin
            skip_next <= 1'b0;
        end else if (ce_i && cycle_start) begin
            skip_next <= src_trip;               // R12 R13
        end
    end

    // off-time counter; a cycle start arriving too soon is ignored in st_low_on
    assign long_off = (off_cnt >= `TMR_W'(`MIN_OFF_CYC));
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            off_cnt <= '0;
        end else if (ce_i) begin
            if (state == st_high_on) begin
                off_cnt <= '0;
            end else if (!long_off) begin
                off_cnt <= off_cnt + `TMR_W'(1);
            end
        end
    end

    // state machine; shutdown (supply or enable lost) and hiccup take precedence
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= st_off;
        end else if (ce_i) begin
            if (!active) begin
                state <= st_off;                 // R17
            end else if (hiccup) begin
                state <= st_hiccup;              // R11
            end else begin
                unique case (state)
                    st_off, st_hiccup: begin
                        if (cycle_start) begin
                            state <= st_low_on;
                        end
                    end
                    st_high_on: begin
                        if (overvoltage_guard || !boot_ok || peak_trip) begin
                            state <= st_low_on;  // R7 R8 R10
                        end
                    end
                    st_low_on: begin
                        if (sink_trip) begin
                            state <= st_both_off;   // R14
                        end else if (cycle_start && src_trip) begin
                            state <= st_low_on;     // R12
                        end else if (cycle_start && long_off && boot_ok
                                     && !ovp_hold && !overvoltage_guard && !skip_next) begin
                            state <= st_high_on;    // R6 R13 R9
                        end
                    end
                    st_both_off: begin
                        if (cycle_start) begin
                            state <= (boot_ok && !ovp_hold && !overvoltage_guard && !src_trip)
                                     ? st_high_on : st_low_on;
                        end
                    end
                    default: state <= st_off;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // outputs, registered; the two gates are mutually exclusive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            high_side_on_o <= 1'b0;
            low_side_on_o  <= 1'b0;
        end else if (ce_i) begin
            // high stays on across cycles while boot is good; shutdown and
            // hiccup cut both gates at once so they never lag the status flags
            high_side_on_o <= (state == st_high_on) && boot_ok && !overvoltage_guard
                              && active && !hiccup;                       // R5 R17
            // low side refreshes the boot capacitor while it conducts
            low_side_on_o  <= (state == st_low_on) && !sink_trip && active && !hiccup
                              && (!sink_block || !boot_ok);               // R4 R21
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_external_o <= 1'b0;
            shutdown_o      <= 1'b1;
            hiccup_o        <= 1'b0;
        end else if (ce_i) begin
            mode_external_o <= (mode == external_clock_mode);
            shutdown_o      <= !active;
            hiccup_o        <= hiccup;
        end
    end

    // pin is never driven: external mode releases it to high impedance
    assign freq_set_sync_pin_o    = 1'b0;
    assign freq_set_sync_pin_oe_o = 1'b0;   // R2

endmodule : buck_switching_control_logic
`default_nettype wire

// ==== test_buck_switching_control_logic.sv ====
// self-checking testbench for the buck switching control logic
`timescale 1ns/1ps
`default_nettype none
module test_buck_switching_control_logic;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [15:0] osc_period_i = 16'h0032;
    logic        supply_ok_i = 1'b0;
    logic        enable_ok_i = 1'b0;
    logic        boot_ok_i = 1'b1;
    logic        overvoltage_guard_i = 1'b0;
    logic        fb_below_106_i = 1'b1;
    logic        comp_clamp_i = 1'b0;
    logic        ls_source_limit_i = 1'b0;
    logic        ls_sink_limit_i = 1'b0;
    logic        sync_run = 1'b0;
    logic [7:0]  ramp = 8'h0a;
    logic        peak_limit_i, model_pin, freq_set_sync_pin_o, freq_set_sync_pin_oe_o;
    logic        high_side_on_o, low_side_on_o, mode_external_o, shutdown_o, hiccup_o;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          n;
    logic        seen;
    // pin level: the control logic never drives, so the sync buffer wins
    wire logic   freq_set_sync_pin_i = freq_set_sync_pin_oe_o ? freq_set_sync_pin_o : model_pin;

    buck_switching_control_logic u_dut (.clk_i, .reset_i, .ce_i, .osc_period_i,
        .freq_set_sync_pin_i, .freq_set_sync_pin_o, .freq_set_sync_pin_oe_o, .supply_ok_i,
        .enable_ok_i, .boot_ok_i, .overvoltage_guard_i, .fb_below_106_i, .peak_limit_i,
        .comp_clamp_i, .ls_source_limit_i, .ls_sink_limit_i, .high_side_on_o,
        .low_side_on_o, .mode_external_o, .shutdown_o, .hiccup_o);
    buck_stage_model u_stage (.clk_i, .sync_run_i(sync_run), .ramp_i(ramp),
        .high_side_on_i(high_side_on_o), .peak_limit_o(peak_limit_i), .sync_pin_o(model_pin));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask : check
    task automatic close_out;
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // scenarios; outputs sampled on the falling edge, away from updates
    // ------------------------------------------------------------
    task automatic t_start;
        @(posedge clk_i) supply_ok_i <= 1'b1;
        repeat (20) @(negedge clk_i);
        check(shutdown_o, 1'b1, "woke without enable");
        @(posedge clk_i) enable_ok_i <= 1'b1;
        for (n = 0; n < 20 && shutdown_o !== 1'b0; n++) @(negedge clk_i);
        check(shutdown_o, 1'b0, "no wake");
        for (n = 0; n < 300 && low_side_on_o !== 1'b1; n++) @(negedge clk_i);
        check({high_side_on_o, low_side_on_o}, 2'b01, "no boot charge first");
        for (n = 0; n < 300 && high_side_on_o !== 1'b1; n++) @(negedge clk_i);
        check(high_side_on_o, 1'b1, "no high pulse from oscillator");
        for (n = 0; n < 40 && low_side_on_o !== 1'b1; n++) @(negedge clk_i);
        check({high_side_on_o, low_side_on_o, n < 30}, 3'b011, "peak trip ignored");
    endtask : t_start
    task automatic t_full;
        @(posedge clk_i) ramp <= 8'h00;
        for (n = 0; n < 300 && high_side_on_o !== 1'b1; n++) @(negedge clk_i);
        for (n = 0; n < 400 && high_side_on_o === 1'b1; n++) @(negedge clk_i);
        check(16'(n), 16'd400, "full duty broken");
        @(posedge clk_i) boot_ok_i <= 1'b0;
        repeat (10) @(negedge clk_i);
        check({high_side_on_o, low_side_on_o}, 2'b01, "no boot refresh");
        @(posedge clk_i);
        boot_ok_i <= 1'b1;
        ramp <= 8'h0a;
    endtask : t_full
    task automatic t_ovp;
        @(posedge clk_i);
        overvoltage_guard_i <= 1'b1;
        fb_below_106_i <= 1'b0;
        repeat (10) @(negedge clk_i);
        check({high_side_on_o, low_side_on_o}, 2'b01, "overvoltage not obeyed");
        @(posedge clk_i) overvoltage_guard_i <= 1'b0;
        seen = 1'b0;
        repeat (300) begin
            @(negedge clk_i);
            seen |= high_side_on_o;
        end
        check(seen, 1'b0, "restart above 106 percent");
        @(posedge clk_i) fb_below_106_i <= 1'b1;
        for (n = 0; n < 300 && high_side_on_o !== 1'b1; n++) @(negedge clk_i);
        check(high_side_on_o, 1'b1, "no restart after overvoltage");
    endtask : t_ovp
    task automatic t_source;
        @(posedge clk_i) ls_source_limit_i <= 1'b1;
        repeat (40) @(negedge clk_i);
        seen = 1'b0;
        repeat (300) begin
            @(negedge clk_i);
            seen |= high_side_on_o | !low_side_on_o;
        end
        check(seen, 1'b0, "pulse not skipped");
        @(posedge clk_i) ls_source_limit_i <= 1'b0;
        for (n = 0; n < 300 && high_side_on_o !== 1'b1; n++) @(negedge clk_i);
        check(high_side_on_o, 1'b1, "no resume");
    endtask : t_source
    task automatic t_sink;
        for (n = 0; n < 300 && low_side_on_o !== 1'b1; n++) @(negedge clk_i);
        @(posedge clk_i) ls_sink_limit_i <= 1'b1;
        repeat (8) @(negedge clk_i);
        check({high_side_on_o, low_side_on_o}, 2'b00, "sink trip ignored");
        @(posedge clk_i) ls_sink_limit_i <= 1'b0;
        seen = 1'b0;
        for (n = 0; n < 400 && low_side_on_o !== 1'b1; n++) begin
            @(negedge clk_i);
            seen |= high_side_on_o;
        end
        check({seen, low_side_on_o}, 2'b11, "low back without high pulse");
    endtask : t_sink
    task automatic t_sync;
        @(posedge clk_i) sync_run <= 1'b1;
        for (n = 0; n < 40 && mode_external_o !== 1'b1; n++) @(negedge clk_i);
        check({mode_external_o, freq_set_sync_pin_oe_o, freq_set_sync_pin_o},
              3'b100, "no external mode");
        repeat (100) @(negedge clk_i);
        @(posedge clk_i) sync_run <= 1'b0;
        for (n = 0; n < 2200 && mode_external_o !== 1'b0; n++) @(negedge clk_i);
        check({mode_external_o, n >= 1980}, 2'b01, "sync loss timing");
    endtask : t_sync
    task automatic t_faults;
        @(posedge clk_i) comp_clamp_i <= 1'b1;
        for (n = 0; n < 30000 && hiccup_o !== 1'b1; n++) @(negedge clk_i);
        check({hiccup_o, n > 25000}, 2'b11, "hiccup timing");
        check({high_side_on_o, low_side_on_o}, 2'b00, "switching in hiccup");
        // short oscillator period so the 16384-cycle wait fits the run
        @(posedge clk_i);
        comp_clamp_i <= 1'b0;
        osc_period_i <= 16'h0002;
        for (n = 0; n < 34000 && hiccup_o !== 1'b0; n++) @(negedge clk_i);
        check({hiccup_o, n > 32000}, 2'b01, "hiccup restart timing");
        @(posedge clk_i);
        osc_period_i <= 16'h0032;
        enable_ok_i <= 1'b0;
        for (n = 0; n < 20 && shutdown_o !== 1'b1; n++) @(negedge clk_i);
        check({shutdown_o, high_side_on_o, low_side_on_o}, 3'b100, "no shutdown");
    endtask : t_faults

    // clock, reset and main sequence
    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_start;
        t_full;
        t_ovp;
        t_source;
        t_sink;
        t_sync;
        t_faults;
        close_out;
    end
    // watchdog, well past the expected run of about 310 us
    initial begin
        #480000;
        error_cnt++;
        close_out;
    end
endmodule : test_buck_switching_control_logic
`default_nettype wire
